//--- hw/tec_cfg.svh
// constants of the timer/event counter core: offsets, fields, resets, timing
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TEC_ADDR_RUN   16'hFF30
`define TEC_ADDR_CCC   16'hFF32
`define TEC_ADDR_EVC   16'hFF34
`define TEC_ADDR_CNT   16'hFF40
`define TEC_ADDR_CMP1  16'hFF42
`define TEC_ADDR_CMP2  16'hFF44
`define TEC_ADDR_CAP   16'hFF46
`define TEC_ADDR_CCS   16'hFF5E

// ****************************************************************
// field positions
// ****************************************************************
`define TEC_RUN_WIDTH  0
`define TEC_RUN_WRAP   2
`define TEC_RUN_ENABLE 3
`define TEC_CCC_FUNC   0
`define TEC_CCC_CLR1   2
`define TEC_CCC_CLR2   3
`define TEC_EVC_MODE   1:0
`define TEC_EVC_SMP    3:2
`define TEC_EVC_SEEN   7

// ****************************************************************
// reset values and codes
// ****************************************************************
`define TEC_RUN_RST    8'h00
`define TEC_CCC_RST    8'h00
`define TEC_CCS_RST    8'h11
`define TEC_EVC_RST    8'h00
`define TEC_CODE_EXT   4'hF
`define TEC_CODE_MIN   4'h1
`define TEC_CODE_MAX   4'h9
`define TEC_TOP8       16'h00FF
`define TEC_TOP16      16'hFFFF

// ****************************************************************
// timing
// ****************************************************************
`define TEC_CLK_NS     100
`define TEC_SMP_MASK1  7'h1F
`define TEC_SMP_MASK2  7'h3F
`define TEC_SMP_MASK3  7'h7F

`endif

//--- hw/tec_core.sv
// timer/event counter core: registers, prescaler, counter, compare, capture
//
// Behaviour
// - control register: low nibble drives this counter, high nibble kept, resets 00
// - control bit 0 selects 8-bit counting at 0, 16-bit at 1
// - counter, first compare and second register follow the selected width
// - clock select low nibble: 1..9 fxx/4..fxx/1024, F event pin, else none
// - setting run from zero loads zero on first count clock, then counts
// - clearing run zeroes the counter at once and stops capture and matches
// - writing run one while running leaves the count undisturbed
// - count clock at top wraps to zero and sets the sticky wrap flag
// - reset leaves the counter at zero and stopped
// - clear-on-first-match enables counter clear on first compare hit
// - function bit makes second register compare or capture, with its clear enable
// - an enabled clear source holds the value and clears on next count clock
// - restart before the next count clock starts that clock from zero
// - selector passes prescaler tap or detected event edge to the counter
// - external clock code alone turns the block into an event counter
// - event rate limit set by sampling clock, same for one or both edges
// - event counter reads zero after none or one edge; sticky seen bit helps
// - first compare hit raises its request and the output-port trigger
// - each valid event edge latches the count until the next one
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_core (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register port
  input  wire tec_pkg::tec_bus_s bus,
  output logic [15:0]            rdata,
  // event pin
  input  wire logic              event_input_pin,
  // events and state
  output logic [15:0]            count_value,
  output logic                   first_match_irq,
  output logic                   second_match_irq,
  output logic                   output_port_trigger,
  output logic                   detected_edge_signal
);
  import tec_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] fit(input logic [15:0] v, input logic wide);
    fit = wide ? v : {8'h00, v[7:0]};
  endfunction

  // one-cycle enable from the prescaler tap or the event edge
  function automatic logic count_en(input logic [3:0] code, input logic [9:0] div,
                                    input logic ext);
    logic [9:0] m;
    m = ~(10'h3FF << (code + 4'h1));
    if (code == `TEC_CODE_EXT) begin
      count_en = ext;
    end else if (code >= `TEC_CODE_MIN && code <= `TEC_CODE_MAX) begin
      count_en = (div & m) == m;
    end else begin
      count_en = 1'b0;
    end
  endfunction

  tec_core_state_s s_r;
  tec_core_state_s s_nxt;
  logic            edge_pulse;
  logic            wide;
  logic            run;
  logic            func_cap;
  logic            tick;
  logic            hit1;
  logic            hit2;
  logic            cap_ev;
  logic            wrap_set;
  logic [15:0]     top;
  logic            wr_run;

  // ****************************************************************
  // event pin edge detector
  // ****************************************************************
  tec_edge u_edge (
    .clk        (clk),
    .rst        (rst),
    .pin        (event_input_pin),
    .smp_sel    (s_r.evc[`TEC_EVC_SMP]),
    .mode       (tec_edge_e'(s_r.evc[`TEC_EVC_MODE])),
    .edge_pulse (edge_pulse)
  );

  // ****************************************************************
  // decode of current state
  // ****************************************************************
  assign wide     = s_r.run_ctl[`TEC_RUN_WIDTH];
  assign run      = s_r.run_ctl[`TEC_RUN_ENABLE];
  assign func_cap = s_r.ccc[`TEC_CCC_FUNC];
  assign top      = wide ? `TEC_TOP16 : `TEC_TOP8;
  // external code needs no other setting
  assign tick     = run && count_en(s_r.ccs[3:0], s_r.div, edge_pulse);
  // matches only right after the count moved, and never while stopped
  assign hit1     = run && s_r.fresh && fit(s_r.cnt, wide) == fit(s_r.cmp1, wide);
  assign hit2     = run && s_r.fresh && !func_cap
                    && fit(s_r.cnt, wide) == fit(s_r.cmp2, wide);
  assign cap_ev   = run && edge_pulse;
  assign wr_run   = bus.wr && bus.addr == `TEC_ADDR_RUN;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt       = s_r;
    s_nxt.div   = s_r.div + 10'h001;
    s_nxt.fresh = 1'b0;
    s_nxt.rdata = 16'h0000;
    s_nxt.m1    = hit1;
    s_nxt.m2    = hit2;
    s_nxt.trig  = hit1 || hit2;
    s_nxt.evt   = edge_pulse;
    wrap_set    = 1'b0;

    // counting: pending start or clear loads zero instead of stepping
    if (tick) begin
      s_nxt.fresh = 1'b1;
      if (s_r.start_pend || s_r.clr_pend) begin
        s_nxt.cnt        = 16'h0000;
        s_nxt.start_pend = 1'b0;
        s_nxt.clr_pend   = 1'b0;
      end else if (fit(s_r.cnt, wide) == top) begin
        s_nxt.cnt = 16'h0000;
        wrap_set  = 1'b1;
      end else begin
        s_nxt.cnt = fit(s_r.cnt, wide) + 16'h0001;
      end
    end

    // capture into dedicated register and, in capture mode, the second one
    if (cap_ev) begin
      s_nxt.cap = fit(s_r.cnt, wide);
      if (func_cap) begin
        s_nxt.cmp2 = fit(s_r.cnt, wide);
      end
    end

    // clear sources wait for the following count clock
    if ((hit1 && s_r.ccc[`TEC_CCC_CLR1])
        || (hit2 && s_r.ccc[`TEC_CCC_CLR2])
        || (cap_ev && func_cap && s_r.ccc[`TEC_CCC_CLR2])) begin
      s_nxt.clr_pend = 1'b1;
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `TEC_ADDR_RUN: begin
          s_nxt.run_ctl = bus.wdata[7:0];
          if (!bus.wdata[`TEC_RUN_ENABLE]) begin
            s_nxt.cnt        = 16'h0000;
            s_nxt.start_pend = 1'b0;
            s_nxt.clr_pend   = 1'b0;
            s_nxt.fresh      = 1'b0;
          end else if (!run) begin
            s_nxt.start_pend = 1'b1;
          end
          // a second start while running arms no start and leaves the count alone
        end
        `TEC_ADDR_CCC:  s_nxt.ccc  = bus.wdata[7:0];
        `TEC_ADDR_CCS:  s_nxt.ccs  = bus.wdata[7:0];
        `TEC_ADDR_EVC:  s_nxt.evc  = bus.wdata[7:0];
        `TEC_ADDR_CMP1: s_nxt.cmp1 = bus.wdata;
        `TEC_ADDR_CMP2: s_nxt.cmp2 = bus.wdata;
        default: ;
      endcase
    end

    // hardware sets win over a software clear in the same cycle, except a stopping run write drops the wrap set
    if (wrap_set && !(wr_run && !bus.wdata[`TEC_RUN_ENABLE])) begin
      s_nxt.run_ctl[`TEC_RUN_WRAP] = 1'b1;
    end
    if (edge_pulse) begin
      s_nxt.evc[`TEC_EVC_SEEN] = 1'b1;
    end

    // read data stand in the cycle after the strobe only
    if (bus.rd) begin
      unique case (bus.addr)
        `TEC_ADDR_RUN:  s_nxt.rdata = {8'h00, s_r.run_ctl};
        `TEC_ADDR_CCC:  s_nxt.rdata = {8'h00, s_r.ccc};
        `TEC_ADDR_CCS:  s_nxt.rdata = {8'h00, s_r.ccs};
        `TEC_ADDR_EVC:  s_nxt.rdata = {8'h00, s_r.evc};
        `TEC_ADDR_CNT:  s_nxt.rdata = fit(s_r.cnt, wide);
        `TEC_ADDR_CMP1: s_nxt.rdata = fit(s_r.cmp1, wide);
        `TEC_ADDR_CMP2: s_nxt.rdata = fit(s_r.cmp2, wide);
        `TEC_ADDR_CAP:  s_nxt.rdata = fit(s_r.cap, wide);
        default:        s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r         <= '0;
      s_r.run_ctl <= `TEC_RUN_RST;
      s_r.ccc     <= `TEC_CCC_RST;
      s_r.ccs     <= `TEC_CCS_RST;
      s_r.evc     <= `TEC_EVC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata                = s_r.rdata;
  assign count_value          = s_r.cnt;
  assign first_match_irq      = s_r.m1;
  assign second_match_irq     = s_r.m2;
  assign output_port_trigger  = s_r.trig;
  assign detected_edge_signal = s_r.evt;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_clear_src;
    s_r.clr_pend && run && !tick && !bus.wr;
  endsequence

  sequence seq_clear_tick;
    s_r.clr_pend && run && tick && !bus.wr;
  endsequence

  sequence seq_stop_wr;
    wr_run && !bus.wdata[`TEC_RUN_ENABLE];
  endsequence

  sequence seq_start_wr;
    wr_run && bus.wdata[`TEC_RUN_ENABLE] && !run;
  endsequence

  stop_zeroes_a: assert property (
    wr_run && !bus.wdata[`TEC_RUN_ENABLE]
    |=> s_r.cnt == 16'h0000 ##1 (s_r.cnt == 16'h0000 && !s_r.m1))
    else $error("counter not zero after stop");

  restart_quiet_a: assert property (
    run && wr_run && bus.wdata[`TEC_RUN_ENABLE] && !tick && !s_r.start_pend
    |=> s_r.cnt == $past(s_r.cnt) && !s_r.start_pend)
    else $error("second start disturbed the count");

  start_zero_a: assert property (
    s_r.start_pend && tick && !bus.wr |=> s_r.cnt == 16'h0000 && !s_r.start_pend)
    else $error("first count clock did not load zero");

  wrap_set_a: assert property (
    tick && !s_r.start_pend && !s_r.clr_pend && fit(s_r.cnt, wide) == top && !bus.wr
    |=> s_r.cnt == 16'h0000 && s_r.run_ctl[`TEC_RUN_WRAP])
    else $error("wrap missing at top");

  wrap_sticky_a: assert property (
    s_r.run_ctl[`TEC_RUN_WRAP] && !wr_run |=> s_r.run_ctl[`TEC_RUN_WRAP])
    else $error("wrap flag lost without a write");

  clear_hold_a: assert property (
    seq_clear_src |=> s_r.cnt == $past(s_r.cnt))
    else $error("count moved before pending clear");

  clear_tick_a: assert property (
    seq_clear_tick |=> s_r.cnt == 16'h0000 ##1 !s_r.clr_pend || tick)
    else $error("pending clear not applied");

  first_hit_a: assert property (
    hit1 |=> first_match_irq && output_port_trigger ##1 !first_match_irq)
    else $error("first match pulse wrong");

  capture_a: assert property (
    cap_ev && !bus.wr |=> s_r.cap == fit($past(s_r.cnt), $past(wide)))
    else $error("capture value wrong");

  narrow_a: assert property (
    !wide && !bus.wr |=> s_r.cnt[15:8] == 8'h00)
    else $error("high byte moved in 8-bit mode");

  idle_a: assert property (
    !run && !bus.wr |=> s_r.cnt == 16'h0000 && !s_r.fresh)
    else $error("stopped counter not at zero");

  second_hit_a: assert property (
    hit2 |=> second_match_irq && output_port_trigger ##1 !second_match_irq)
    else $error("second match pulse wrong");

  sel_read_a: assert property (
    bus.rd && bus.addr == `TEC_ADDR_CCS |=> rdata == {8'h00, $past(s_r.ccs)})
    else $error("clock select read back wrong");

  count_hold_a: assert property (
    run && !tick && !bus.wr |=> s_r.cnt == $past(s_r.cnt))
    else $error("count moved without a count clock");

  count_step_a: assert property (
    tick && !s_r.start_pend && !s_r.clr_pend && fit(s_r.cnt, wide) != top && !bus.wr
    |=> s_r.cnt == fit($past(s_r.cnt), $past(wide)) + 16'h0001)
    else $error("count did not step by one");

  bad_code_a: assert property (
    run && (s_r.ccs[3:0] == 4'h0
            || (s_r.ccs[3:0] > `TEC_CODE_MAX && s_r.ccs[3:0] != `TEC_CODE_EXT)) |-> !tick)
    else $error("prohibited code produced a count clock");

  tick_rate_a: assert property (
    tick && s_r.ccs[3:0] == 4'h1 && !bus.wr |=> !tick [*3])
    else $error("fastest tap ticked too often");

  start_arm_a: assert property (
    wr_run && bus.wdata[`TEC_RUN_ENABLE] && !run |=> s_r.start_pend)
    else $error("start not armed");

  restart_zero_a: assert property (
    seq_stop_wr ##[1:6] seq_start_wr |=> s_r.start_pend && s_r.cnt == 16'h0000)
    else $error("restart does not begin from zero");

  cap_hold_a: assert property (
    !cap_ev |=> s_r.cap == $past(s_r.cap))
    else $error("capture changed without an edge");

  cap_stopped_a: assert property (
    !run && edge_pulse && !bus.wr |=> s_r.cmp2 == $past(s_r.cmp2))
    else $error("capture while stopped");

  seen_set_a: assert property (
    edge_pulse |=> s_r.evc[`TEC_EVC_SEEN])
    else $error("edge-seen flag not set");

  edge_out_a: assert property (
    edge_pulse |=> detected_edge_signal)
    else $error("detected edge not shown");

  narrow_read_a: assert property (
    bus.rd && bus.addr == `TEC_ADDR_CNT && !wide |=> rdata[15:8] == 8'h00)
    else $error("high byte read in 8-bit mode");

  clear_arm_a: assert property (
    hit1 && s_r.ccc[`TEC_CCC_CLR1] && !bus.wr |=> s_r.clr_pend)
    else $error("first match clear not armed");

  capture_clear_a: assert property (
    cap_ev && func_cap && s_r.ccc[`TEC_CCC_CLR2] && !bus.wr
    |=> s_r.clr_pend && s_r.cmp2 == fit($past(s_r.cnt), $past(wide)))
    else $error("capture clear not armed");

endmodule // tec_core

//--- hw/tec_edge.sv
// event pin synchroniser, sampling filter and edge detector
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_edge (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // pin and mode
  input  wire logic              pin,
  input  wire logic [1:0]        smp_sel,
  input  wire tec_pkg::tec_edge_e mode,
  // detected edge
  output logic                   edge_pulse
);
  import tec_pkg::*;

  tec_edge_state_s s_r;
  tec_edge_state_s s_nxt;
  logic            smp_tick;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.sync    = {s_r.sync[1:0], pin};
    s_nxt.smp_div = s_r.smp_div + 7'h01;
    s_nxt.pulse   = 1'b0;
    // a level counts once the second and third stages agree
    if (s_r.sync[1] == s_r.sync[2]) begin
      s_nxt.lvl = s_r.sync[2];
    end
    unique case (smp_sel)
      2'd0: smp_tick = 1'b1;
      2'd1: smp_tick = (s_r.smp_div & `TEC_SMP_MASK1) == `TEC_SMP_MASK1;
      2'd2: smp_tick = (s_r.smp_div & `TEC_SMP_MASK2) == `TEC_SMP_MASK2;
      2'd3: smp_tick = (s_r.smp_div & `TEC_SMP_MASK3) == `TEC_SMP_MASK3;
    endcase
    // three equal samples needed; shorter pulses are dropped
    if (smp_tick) begin
      s_nxt.hist = {s_r.hist[1:0], s_r.lvl};
      if ((&s_nxt.hist) != s_r.flt && ((&s_nxt.hist) || !(|s_nxt.hist))) begin
        s_nxt.flt = &s_nxt.hist;
        unique case (mode)
          TEC_EDGE_FALL: s_nxt.pulse = !s_nxt.flt;
          TEC_EDGE_RISE: s_nxt.pulse = s_nxt.flt;
          TEC_EDGE_BOTH: s_nxt.pulse = 1'b1;
          TEC_EDGE_NONE: s_nxt.pulse = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign edge_pulse = s_r.pulse;

endmodule // tec_edge

//--- hw/tec_pkg.sv
// types shared by the timer/event counter core
package tec_pkg;

  typedef enum logic [1:0] {
    TEC_EDGE_FALL,
    TEC_EDGE_RISE,
    TEC_EDGE_BOTH,
    TEC_EDGE_NONE
  } tec_edge_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tec_bus_s;

  typedef struct packed {
    logic [2:0] sync;
    logic       lvl;
    logic [6:0] smp_div;
    logic [2:0] hist;
    logic       flt;
    logic       pulse;
  } tec_edge_state_s;

  typedef struct packed {
    logic [7:0]  run_ctl;
    logic [7:0]  ccc;
    logic [7:0]  ccs;
    logic [7:0]  evc;
    logic [15:0] cnt;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [15:0] cap;
    logic [9:0]  div;
    logic        start_pend;
    logic        clr_pend;
    logic        fresh;
    logic        m1;
    logic        m2;
    logic        trig;
    logic        evt;
    logic [15:0] rdata;
  } tec_core_state_s;

endpackage

//--- sim/tec_core_tb.sv
// self-checking bench of the timer/event counter core
`timescale 1ns/1ps
`include "tec_cfg.svh"
module tec_core_tb;
  import tec_pkg::*;
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  tec_bus_s    bus      = '0;
  logic        src_go   = 1'b0;
  logic [7:0]  src_n    = 8'h00;
  logic [9:0]  src_half = 10'h005;
  logic        rd_d     = 1'b0;
  logic [15:0] rdata, count_value, ua;
  logic        first_match_irq, second_match_irq, output_port_trigger;
  logic        detected_edge_signal, pin, src_busy;
  logic [15:0] exp_q[$];
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          n_edge     = 0;
  int          seed       = 32'hD401;
  int          n, p, e0, k, ed;

  always #50 clk = ~clk;

  tec_core tec_core_inst (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .event_input_pin(pin), .count_value(count_value), .first_match_irq(first_match_irq),
    .second_match_irq(second_match_irq), .output_port_trigger(output_port_trigger),
    .detected_edge_signal(detected_edge_signal));
  tec_pulse_src tec_pulse_src_inst (.clk(clk), .go(src_go), .n_pulses(src_n),
    .half_cyc(src_half), .pin(pin), .busy(src_busy));

  // ****************************************************************
  // comparison, waits and bus cycles
  // ****************************************************************
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    cmp_count++;
    if (seen_v !== exp_v) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask

  function automatic logic hit(input int c, input logic [15:0] v);
    case (c)
      0: return count_value === v;
      1: return count_value !== v;
      2: return first_match_irq === 1'b1;
      3: return second_match_irq === 1'b1;
      4: return detected_edge_signal === 1'b1;
      default: return src_busy === 1'b0;
    endcase
  endfunction

  // n ends as the number of edges waited
  task automatic wait_for(input int c, input logic [15:0] v, input int bound);
    n = 0;
    while (!hit(c, v)) begin
      @(posedge clk);
      n++;
      if (n > bound) begin
        n_mismatch++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, count_value, v);
        tally_and_finish();
      end
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask

  task automatic pulses(input int cnt, input int half);
    src_n    <= 8'(cnt);
    src_half <= 10'(half);
    src_go   <= 1'b1;
    @(posedge clk);
    src_go <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= bus.rd;
    if (detected_edge_signal === 1'b1) n_edge++;
    if (rd_d) check(rdata, exp_q.pop_front());
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`TEC_ADDR_RUN, 16'h0000);
    rd(`TEC_ADDR_CCC, 16'h0000);
    rd(`TEC_ADDR_CCS, 16'h0011);
    rd(`TEC_ADDR_CNT, 16'h0000);
    ua = 16'hFF50 + 16'({$random(seed)} % 7) * 16'h0002;
    wr(ua, 16'h00FF);
    rd(ua, 16'h0000);
    wr(`TEC_ADDR_RUN, 16'h00A0);
    rd(`TEC_ADDR_RUN, 16'h00A0);
    for (int c = 1; c <= 9; c++) begin
      wr(`TEC_ADDR_RUN, 16'h0000);
      wr(`TEC_ADDR_CCS, 16'(c));
      wr(`TEC_ADDR_RUN, 16'h0008);
      p = 2 << c;
      wait_for(0, 16'h0001, 2 * p + 8);
      check(16'(n >= p), 16'h0001);
      wait_for(1, 16'h0001, p + 2);
      check(16'(n), 16'(p));
    end
    // prohibited code never ticks
    wr(`TEC_ADDR_RUN, 16'h0000);
    wr(`TEC_ADDR_CCS, ($random(seed) & 1) ? 16'h0000 : 16'(10 + {$random(seed)} % 5));
    wr(`TEC_ADDR_RUN, 16'h0008);
    repeat (40) @(posedge clk);
    check(count_value, 16'h0000);
    // wrap, sticky flag, rewrite of run, stop
    wr(`TEC_ADDR_RUN, 16'h0000);
    wr(`TEC_ADDR_CCS, 16'h0001);
    wr(`TEC_ADDR_RUN, 16'h0008);
    wait_for(0, 16'h00FF, 1100);
    wait_for(1, 16'h00FF, 6);
    check(count_value, 16'h0000);
    rd(`TEC_ADDR_RUN, 16'h000C);
    wait_for(0, 16'h0003, 20);
    wr(`TEC_ADDR_RUN, 16'h0008);
    check(16'(count_value >= 16'h0003), 16'h0001);
    rd(`TEC_ADDR_RUN, 16'h0008);
    wr(`TEC_ADDR_RUN, 16'h0000);
    @(posedge clk);
    check(count_value, 16'h0000);
    // width select
    wr(`TEC_ADDR_RUN, 16'h0001);
    wr(`TEC_ADDR_CMP1, 16'h1234);
    rd(`TEC_ADDR_CMP1, 16'h1234);
    wr(`TEC_ADDR_RUN, 16'h0000);
    rd(`TEC_ADDR_CMP1, 16'h0034);
    wr(`TEC_ADDR_RUN, 16'h0009);
    wait_for(0, 16'h0100, 1200);
    rd(`TEC_ADDR_CNT, 16'h0100);
    // clear on first compare
    wr(`TEC_ADDR_RUN, 16'h0000);
    e0 = 3 + {$random(seed)} % 4;
    wr(`TEC_ADDR_CMP1, 16'(e0));
    wr(`TEC_ADDR_CCC, 16'h0004);
    wr(`TEC_ADDR_RUN, 16'h0008);
    wait_for(2, 16'h0000, 60);
    check(count_value, 16'(e0));
    check(16'(output_port_trigger), 16'h0001);
    wait_for(1, 16'(e0), 6);
    check(count_value, 16'h0000);
    check(16'(n), 16'h0003);
    // second register as compare with clear
    wr(`TEC_ADDR_RUN, 16'h0000);
    wr(`TEC_ADDR_CMP2, 16'h0002);
    wr(`TEC_ADDR_CCC, 16'h0008);
    wr(`TEC_ADDR_RUN, 16'h0008);
    wait_for(3, 16'h0000, 60);
    check(count_value, 16'h0002);
    check(16'(output_port_trigger), 16'h0001);
    wait_for(1, 16'h0002, 6);
    check(count_value, 16'h0000);
    // event counting: edge mode and sampling rate i in both fields
    wr(`TEC_ADDR_CCC, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(`TEC_ADDR_RUN, 16'h0000);
      wr(`TEC_ADDR_EVC, 16'(i * 5));
      wr(`TEC_ADDR_CCS, 16'h000F);
      wr(`TEC_ADDR_RUN, 16'h0008);
      k = 1 + {$random(seed)} % 4;
      e0 = n_edge;
      // half widths keep three samples per level plus phase margin
      pulses(k, i == 0 ? 4 + {$random(seed)} % 4 : 64 << i);
      repeat (2) @(posedge clk);
      wait_for(5, 16'h0000, 6000);
      repeat (600) @(posedge clk);
      ed = (i < 2) ? k : (i == 2 ? 2 * k : 0);
      check(16'(n_edge - e0), 16'(ed));
      rd(`TEC_ADDR_CNT, ed == 0 ? 16'h0000 : 16'(ed - 1));
    end
    // capture into both registers, then clear on next tick
    wr(`TEC_ADDR_RUN, 16'h0000);
    wr(`TEC_ADDR_EVC, 16'h0001);
    wr(`TEC_ADDR_CCC, 16'h0009);
    wr(`TEC_ADDR_CCS, 16'h0009);
    wr(`TEC_ADDR_RUN, 16'h0008);
    wait_for(0, 16'h0001, 2200);
    pulses(1, 8);
    wait_for(4, 16'h0000, 40);
    rd(`TEC_ADDR_CMP2, 16'h0001);
    rd(`TEC_ADDR_CAP, 16'h0001);
    wait_for(1, 16'h0001, 1100);
    check(count_value, 16'h0000);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule // tec_core_tb

//--- sim/tec_pulse_src.sv
// pulse source model standing in front of the event pin
`timescale 1ns/1ps
module tec_pulse_src (
  // clock
  input  wire logic       clk,
  // request
  input  wire logic       go,
  input  wire logic [7:0] n_pulses,
  input  wire logic [9:0] half_cyc,
  // pin and status
  output logic            pin,
  output logic            busy
);
  // ****************************************************************
  // pulse train, pin rests low between trains
  // ****************************************************************
  initial begin
    pin  = 1'b0;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      for (int i = 0; i < n_pulses; i++) begin
        pin <= 1'b1;
        repeat (half_cyc) @(posedge clk);
        pin <= 1'b0;
        repeat (half_cyc) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule // tec_pulse_src
